// ---- logic/rifc_map.vh ----
// Purpose: constants for the remote input function control block
// Assumes: 50 MHz pclk, APB register access, 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
`ifndef RIFC_MAP_VH
`define RIFC_MAP_VH

// register byte offsets
`define RIFC_OFS_MODE     8'h00
`define RIFC_OFS_BRIGHT   8'h04
`define RIFC_OFS_STATUS   8'h08
`define RIFC_OFS_MASK     8'h0C
`define RIFC_OFS_STATE    8'h10

// mode codes, one nibble per input, button in the lowest nibble
`define RIFC_MODE_W       4
`define RIFC_M_NONE       4'h0
`define RIFC_M_PEAK_HOLD  4'h1
`define RIFC_M_DISP_HOLD  4'h2
`define RIFC_M_PEAK_MEM   4'h3
`define RIFC_M_VALLEY_MEM 4'h4
`define RIFC_M_TOGGLE     4'h5
`define RIFC_M_ACK        4'h6
`define RIFC_M_ACCESS     4'h7
`define RIFC_M_DIM        4'h8
`define RIFC_M_ZERO       4'h9
`define RIFC_M_GT_RESET   4'hA
`define RIFC_M_INHIBIT    4'hB

// brightness fields and reset values
`define RIFC_BR_NORM      5:0
`define RIFC_BR_DIM       13:8
`define RIFC_BR_NORM_RST  6'h3F
`define RIFC_BR_DIM_RST   6'h07

// status event bits
`define RIFC_EV_MEM_CLR   0
`define RIFC_EV_ACK       1
`define RIFC_EV_ZERO      2
`define RIFC_EV_GT        3
`define RIFC_EV_RECALL    4

// display message codes
`define RIFC_MSG_NONE     3'h0
`define RIFC_MSG_PHOLD    3'h1
`define RIFC_MSG_DHOLD    3'h2
`define RIFC_MSG_TAG_PEAK 3'h3
`define RIFC_MSG_TAG_VAL  3'h4
`define RIFC_MSG_RESET    3'h5

// times in their own units
`define RIFC_CLK_HZ       50000000
`define RIFC_IND_PERIOD_S 8
`define RIFC_RECALL_S     20
`define RIFC_LONG_MS      2000
`define RIFC_MSG_SHOW_MS  500
`define RIFC_DEBOUNCE_MS  10
`define RIFC_CYC_PER_MS   (`RIFC_CLK_HZ / 1000)

`endif

// ---- logic/rifc_top.v ----
// Purpose: remote contact and button function control with APB registers
// Assumes: contacts pull inputs low when shorted; one measured channel bus
// Notes:   all outputs registered; long counts are parameters
`timescale 1ns/1ps

`include "rifc_map.vh"

module rifc_top #(
	parameter [31:0] IND_PERIOD_CYC = `RIFC_IND_PERIOD_S * `RIFC_CLK_HZ,
	parameter [31:0] RECALL_CYC     = `RIFC_RECALL_S * `RIFC_CLK_HZ,
	parameter [31:0] LONG_CYC       = `RIFC_LONG_MS * `RIFC_CYC_PER_MS,
	parameter [31:0] MSG_SHOW_CYC   = `RIFC_MSG_SHOW_MS * `RIFC_CYC_PER_MS,
	parameter [31:0] DEBOUNCE_CYC   = `RIFC_DEBOUNCE_MS * `RIFC_CYC_PER_MS
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  rin_n,
	input  wire        button_n,
	input  wire [15:0] meas_value,
	input  wire        meas_valid,
	output reg  [15:0] shown_value,
	output reg  [2:0]  msg_code,
	output reg         alarm_acknowledge,
	output reg         setup_gate,
	output reg  [5:0]  brightness,
	output reg         total_zero,
	output reg         grand_reset,
	output reg         count_inhibit,
	output reg         irq
);

localparam N_IN = 5;
localparam [3:0] ST_IDLE  = 4'h1;
localparam [3:0] ST_FLASH = 4'h2;
localparam [3:0] ST_SHOW  = 4'h4;
localparam [3:0] ST_RSTM  = 4'h8;

////////////////////////////////////////////////////////////////////////////
// functions

// button accepts only a subset; anything else behaves as none
function [3:0] eff_mode;
	input [19:0]  modes;
	input integer idx;
	reg   [3:0]   m;
	begin
		m = modes[idx*4 +: 4];
		eff_mode = m;
		if (idx == 0 && m != `RIFC_M_PEAK_MEM && m != `RIFC_M_VALLEY_MEM &&
		    m != `RIFC_M_TOGGLE && m != `RIFC_M_ACK) begin
			eff_mode = `RIFC_M_NONE;
		end
	end
endfunction

// any input with this mode whose bit is set in vec
function any_in;
	input [4:0]  vec;
	input [19:0] modes;
	input [3:0]  mode;
	integer      i;
	begin
		any_in = 1'b0;
		for (i = 0; i < N_IN; i = i + 1) begin
			if (vec[i] && eff_mode(modes, i) == mode) begin
				any_in = 1'b1;
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// registers

reg [4:0]  sync1_ff, sync2_ff, db_ff, db_prev_ff;
reg [18:0] db_cnt_ff [0:N_IN-1];
reg [19:0] mode_ff;
reg [5:0]  br_norm_ff, br_dim_ff;
reg [4:0]  status_ff, mask_ff;
reg [3:0]  state_ff;
reg        sel_valley_ff, toggle_ff;
reg [31:0] rc_cnt_ff, hold_cnt_ff, ind_cnt_ff;
reg [15:0] peak_ff, valley_ff;

////////////////////////////////////////////////////////////////////////////
// input synchroniser and debounce

integer k;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync1_ff   <= 5'h00;
		sync2_ff   <= 5'h00;
		db_ff      <= 5'h00;
		db_prev_ff <= 5'h00;
		for (k = 0; k < N_IN; k = k + 1) begin
			db_cnt_ff[k] <= 19'h00000;
		end
	end else begin
		// shorted terminal pulls low, so invert to active high
		sync1_ff   <= ~{rin_n, button_n};
		sync2_ff   <= sync1_ff;
		db_prev_ff <= db_ff;
		for (k = 0; k < N_IN; k = k + 1) begin
			if (sync2_ff[k] == db_ff[k]) begin
				db_cnt_ff[k] <= 19'h00000;
			end else if ({13'h0000, db_cnt_ff[k]} == DEBOUNCE_CYC - 1) begin
				db_ff[k]     <= sync2_ff[k];
				db_cnt_ff[k] <= 19'h00000;
			end else begin
				db_cnt_ff[k] <= db_cnt_ff[k] + 19'h00001;
			end
		end
	end
end

wire [4:0] rise = db_ff & ~db_prev_ff;

wire ph_lvl   = any_in(db_ff, mode_ff, `RIFC_M_PEAK_HOLD);
wire dh_lvl   = any_in(db_ff, mode_ff, `RIFC_M_DISP_HOLD);
wire pm_lvl   = any_in(db_ff, mode_ff, `RIFC_M_PEAK_MEM);
wire vm_lvl   = any_in(db_ff, mode_ff, `RIFC_M_VALLEY_MEM);
wire tg_lvl   = any_in(db_ff, mode_ff, `RIFC_M_TOGGLE);
wire acc_lvl  = any_in(db_ff, mode_ff, `RIFC_M_ACCESS);
wire dim_lvl  = any_in(db_ff, mode_ff, `RIFC_M_DIM);
wire inh_lvl  = any_in(db_ff, mode_ff, `RIFC_M_INHIBIT);
wire pm_rise  = any_in(rise, mode_ff, `RIFC_M_PEAK_MEM);
wire vm_rise  = any_in(rise, mode_ff, `RIFC_M_VALLEY_MEM);
wire tg_rise  = any_in(rise, mode_ff, `RIFC_M_TOGGLE);
wire ack_rise = any_in(rise, mode_ff, `RIFC_M_ACK);
wire z_rise   = any_in(rise, mode_ff, `RIFC_M_ZERO);
wire gt_rise  = any_in(rise, mode_ff, `RIFC_M_GT_RESET);

wire mem_lvl  = pm_lvl | vm_lvl | tg_lvl;
wire mem_rise = pm_rise | vm_rise | tg_rise;
wire mem_clr  = mem_lvl && hold_cnt_ff == LONG_CYC - 1;

////////////////////////////////////////////////////////////////////////////
// memory recall sequencer

reg [3:0]  nxt_state;
reg        nxt_sel_valley, nxt_toggle;
reg [31:0] nxt_rc_cnt;

always @* begin
	nxt_state      = state_ff;
	nxt_sel_valley = sel_valley_ff;
	nxt_toggle     = toggle_ff;
	nxt_rc_cnt     = rc_cnt_ff + 32'h00000001;
	if (mem_clr) begin
		nxt_state  = ST_RSTM;
		nxt_rc_cnt = 32'h00000000;
	end else if (mem_rise) begin
		nxt_rc_cnt = 32'h00000000;
		if (tg_rise) begin
			// first activation shows peak, next one valley
			nxt_sel_valley = toggle_ff;
			nxt_toggle     = ~toggle_ff;
			nxt_state      = ST_FLASH;
		end else begin
			nxt_sel_valley = vm_rise;
			nxt_state      = ST_SHOW;
		end
	end else begin
		case (state_ff)
			ST_FLASH: begin
				if (rc_cnt_ff == MSG_SHOW_CYC - 1) begin
					nxt_state  = ST_SHOW;
					nxt_rc_cnt = 32'h00000000;
				end
			end
			ST_SHOW: begin
				// timeout runs only once the contact is released
				if (mem_lvl) begin
					nxt_rc_cnt = 32'h00000000;
				end else if (rc_cnt_ff == RECALL_CYC - 1) begin
					nxt_state  = ST_IDLE;
					nxt_rc_cnt = 32'h00000000;
				end
			end
			ST_RSTM: begin
				if (rc_cnt_ff == MSG_SHOW_CYC - 1) begin
					nxt_state  = ST_IDLE;
					nxt_rc_cnt = 32'h00000000;
				end
			end
			default: begin
				nxt_state  = ST_IDLE;
				nxt_rc_cnt = 32'h00000000;
			end
		endcase
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_ff      <= ST_IDLE;
		sel_valley_ff <= 1'b0;
		toggle_ff     <= 1'b0;
		rc_cnt_ff     <= 32'h00000000;
		hold_cnt_ff   <= 32'h00000000;
	end else begin
		state_ff      <= nxt_state;
		sel_valley_ff <= nxt_sel_valley;
		toggle_ff     <= nxt_toggle;
		rc_cnt_ff     <= nxt_rc_cnt;
		// saturates so a long hold clears only once
		if (!mem_lvl) begin
			hold_cnt_ff <= 32'h00000000;
		end else if (hold_cnt_ff != LONG_CYC) begin
			hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// extremes and shown value

wire hold_any = ph_lvl | dh_lvl;
wire ind_on   = hold_any && ind_cnt_ff >= IND_PERIOD_CYC - MSG_SHOW_CYC;

// reset is the power-loss path that empties memory
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		peak_ff     <= 16'h0000;
		valley_ff   <= 16'h0000;
		shown_value <= 16'h0000;
		ind_cnt_ff  <= 32'h00000000;
		msg_code    <= `RIFC_MSG_NONE;
	end else begin
		if (mem_clr) begin
			peak_ff   <= meas_value;
			valley_ff <= meas_value;
		end else if (meas_valid) begin
			if ($signed(meas_value) > $signed(peak_ff)) begin
				peak_ff <= meas_value;
			end
			if ($signed(meas_value) < $signed(valley_ff)) begin
				valley_ff <= meas_value;
			end
		end
		if (dh_lvl) begin
			shown_value <= shown_value;
		end else if (ph_lvl) begin
			if (meas_valid && $signed(meas_value) > $signed(shown_value)) begin
				shown_value <= meas_value;
			end
		end else if (state_ff == ST_SHOW) begin
			shown_value <= sel_valley_ff ? valley_ff : peak_ff;
		end else if (meas_valid) begin
			shown_value <= meas_value;
		end
		if (!hold_any || ind_cnt_ff == IND_PERIOD_CYC - 1) begin
			ind_cnt_ff <= 32'h00000000;
		end else begin
			ind_cnt_ff <= ind_cnt_ff + 32'h00000001;
		end
		if (state_ff == ST_RSTM) begin
			msg_code <= `RIFC_MSG_RESET;
		end else if (state_ff == ST_FLASH) begin
			msg_code <= sel_valley_ff ? `RIFC_MSG_TAG_VAL
			                          : `RIFC_MSG_TAG_PEAK;
		end else if (ind_on) begin
			msg_code <= dh_lvl ? `RIFC_MSG_DHOLD
			                   : `RIFC_MSG_PHOLD;
		end else begin
			msg_code <= `RIFC_MSG_NONE;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// alarm, access, brightness and totaliser controls

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		alarm_acknowledge <= 1'b0;
		setup_gate        <= 1'b0;
		brightness        <= `RIFC_BR_NORM_RST;
		total_zero        <= 1'b0;
		grand_reset       <= 1'b0;
		count_inhibit     <= 1'b0;
	end else begin
		// one pulse acts on every alarm needing acknowledgement
		alarm_acknowledge <= ack_rise;
		setup_gate        <= acc_lvl;
		brightness        <= dim_lvl ? br_dim_ff : br_norm_ff;
		total_zero        <= z_rise;
		grand_reset       <= gt_rise;
		count_inhibit     <= inh_lvl;
	end
end

////////////////////////////////////////////////////////////////////////////
// APB slave, one wait state on every access

wire       acc    = psel & penable;
wire       wr_en  = acc & pready & pwrite;
wire       hit    = paddr == `RIFC_OFS_MODE   || paddr == `RIFC_OFS_BRIGHT ||
                    paddr == `RIFC_OFS_STATUS || paddr == `RIFC_OFS_MASK   ||
                    paddr == `RIFC_OFS_STATE;
wire [4:0] events;
wire [4:0] w1c;
wire [4:0] nxt_status;

assign events[`RIFC_EV_MEM_CLR] = mem_clr;
assign events[`RIFC_EV_ACK]     = ack_rise;
assign events[`RIFC_EV_ZERO]    = z_rise;
assign events[`RIFC_EV_GT]      = gt_rise;
assign events[`RIFC_EV_RECALL]  = mem_rise;
assign w1c = (wr_en && paddr == `RIFC_OFS_STATUS) ? pwdata[4:0] : 5'h00;
// a new event in the clearing cycle survives
assign nxt_status = (status_ff & ~w1c) | events;

reg [31:0] rd_mux;
always @* begin
	case (paddr)
		`RIFC_OFS_MODE:   rd_mux = {12'h000, mode_ff};
		`RIFC_OFS_BRIGHT: rd_mux = {18'h00000, br_dim_ff, 2'h0, br_norm_ff};
		`RIFC_OFS_STATUS: rd_mux = {27'h0000000, status_ff};
		`RIFC_OFS_MASK:   rd_mux = {27'h0000000, mask_ff};
		`RIFC_OFS_STATE:  rd_mux = {21'h000000, state_ff, sel_valley_ff,
		                            toggle_ff, db_ff};
		default:          rd_mux = 32'h00000000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata     <= 32'h00000000;
		pready     <= 1'b0;
		pslverr    <= 1'b0;
		mode_ff    <= 20'h00000;
		br_norm_ff <= `RIFC_BR_NORM_RST;
		br_dim_ff  <= `RIFC_BR_DIM_RST;
		status_ff  <= 5'h00;
		mask_ff    <= 5'h00;
		irq        <= 1'b0;
	end else begin
		pready    <= acc & ~pready;
		pslverr   <= acc & ~pready & ~hit;
		prdata    <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
		status_ff <= nxt_status;
		irq       <= |(nxt_status & mask_ff);
		if (wr_en && paddr == `RIFC_OFS_MODE) begin
			mode_ff <= pwdata[19:0];
		end
		if (wr_en && paddr == `RIFC_OFS_BRIGHT) begin
			br_norm_ff <= pwdata[`RIFC_BR_NORM];
			br_dim_ff  <= pwdata[`RIFC_BR_DIM];
		end
		if (wr_en && paddr == `RIFC_OFS_MASK) begin
			mask_ff <= pwdata[4:0];
		end
	end
end

endmodule

// ---- dv/rifc_top_monitor.sv ----
// Purpose: port-level checks for rifc_top
// Assumes: one pclk domain, presetn async active low
// Notes:   mode and brightness shadowed from apb writes
`timescale 1ns/1ps
module rifc_top_monitor (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire [2:0]  msg_code,
	input wire        alarm_acknowledge,
	input wire        setup_gate,
	input wire [5:0]  brightness,
	input wire        total_zero,
	input wire        grand_reset,
	input wire        count_inhibit
);
////////////////////////////////////////////////////////////////////////
	reg  [19:0] mode_ff;
	reg  [13:0] br_ff;
	wire        wr_hit = psel & penable & pready & pwrite;
	// button nibble left out: it may not pick these modes
	function automatic has(input [3:0] c);
		has = (mode_ff[7:4] == c) | (mode_ff[11:8] == c)
			| (mode_ff[15:12] == c) | (mode_ff[19:16] == c);
	endfunction
	wire acc = has(4'h7);
	wire dim = has(4'h8);
	wire zro = has(4'h9);
	wire gtr = has(4'hA);
	wire inh = has(4'hB);
	wire ack = has(4'h6) | (mode_ff[3:0] == 4'h6);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 20'h00000;
			br_ff <= 14'h073F;
		end else if (wr_hit && paddr == 8'h00) begin
			mode_ff <= pwdata[19:0];
		end else if (wr_hit && paddr == 8'h04) begin
			br_ff <= pwdata[13:0];
		end
	end
////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property ($rose(penable) && psel |->
		!pready ##1 pready) else $error("wait state wrong");
	a_err_map: assert property (pready |-> pslverr ==
		!(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
		else $error("pslverr wrong for address");
	a_none_quiet: assert property (
		$past(mode_ff) == 20'h00000 && mode_ff == 20'h00000 |->
		!(setup_gate | count_inhibit | alarm_acknowledge
		| total_zero | grand_reset)) else $error("mode none acted");
	a_ack_pulse: assert property (
		alarm_acknowledge |-> $past(ack) ##1 !alarm_acknowledge)
		else $error("ack pulse wrong");
	a_gate_mode: assert property (setup_gate |-> $past(acc))
		else $error("setup gate without access mode");
	a_dim_norm: assert property (
		!$past(dim) && !dim && $stable(br_ff) |->
		brightness == br_ff[5:0]) else $error("brightness wrong");
	a_zero_pulse: assert property (
		total_zero |-> $past(zro) ##1 !total_zero)
		else $error("zero pulse wrong");
	a_grand_pulse: assert property (
		grand_reset |-> $past(gtr) ##1 !grand_reset)
		else $error("grand reset pulse wrong");
	a_inhibit_mode: assert property (count_inhibit |-> $past(inh))
		else $error("inhibit without its mode");
	a_msg_legal: assert property (msg_code <= 3'h5)
		else $error("message code out of range");
endmodule
bind rifc_top rifc_top_monitor i_mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .msg_code,
	.alarm_acknowledge, .setup_gate, .brightness, .total_zero,
	.grand_reset, .count_inhibit);

// ---- dv/rifc_contacts.sv ----
// Purpose: external contacts on the remote inputs and button
// Assumes: pull-up on each pin, closed contact pulls low
// Notes:   each change bounces back for one cycle
`timescale 1ns/1ps
module rifc_contacts (
	input  wire logic       pclk,
	input  wire logic [4:0] press,
	output logic      [3:0] rin_n,
	output logic            button_n
);
	logic [4:0] prev_ff = 5'h00;
	logic [4:0] chg_ff  = 5'h00;
	logic [4:0] pin_ff  = 5'h1F;
	// bounce stays shorter than the debounce span on purpose
	always @(posedge pclk) begin
		prev_ff <= press;
		chg_ff <= press ^ prev_ff;
		pin_ff <= ~(press ^ chg_ff);
	end
	assign rin_n    = pin_ff[4:1];
	assign button_n = pin_ff[0];
endmodule

// ---- dv/rifc_top_tb.sv ----
// Purpose: self-checking bench for rifc_top
// Assumes: short count parameters, contacts model on the pins
// Notes:   pulses are seen through sticky status bits
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	check_count++; \
	if ((s) !== (e)) begin \
		err_total++; \
		$display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
	end \
end
module rifc_top_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic        pready, pslverr, er_q, meas_valid = 1, irq;
	logic [15:0] meas_value = 16'h0000, shown_value;
	logic [4:0]  key = 5'h00;
	logic [3:0]  rin_n;
	logic [2:0]  msg_code;
	logic [5:0]  brightness;
	logic        button_n, alarm_acknowledge, setup_gate;
	logic        total_zero, grand_reset, count_inhibit;
	int          err_total = 0, check_count = 0;
	always #10 pclk = ~pclk;
	rifc_contacts i_sw (.pclk(pclk), .press(key), .rin_n(rin_n),
		.button_n(button_n));
	rifc_top #(.IND_PERIOD_CYC(50), .RECALL_CYC(200), .LONG_CYC(100),
		.MSG_SHOW_CYC(10), .DEBOUNCE_CYC(4)) i_dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rin_n, .button_n, .meas_value, .meas_valid,
		.shown_value, .msg_code, .alarm_acknowledge, .setup_gate,
		.brightness, .total_zero, .grand_reset, .count_inhibit, .irq);
////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			err_total++;
		rd_q = prdata;
		er_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("read", e, rd_q)
	endtask
	task automatic push(input logic [4:0] v);
		key <= v;
		repeat (20) @(posedge pclk);
	endtask
	// bounded wait, the message window repeats every 50 cycles
	task automatic wait_msg(input logic [2:0] m);
		int n;
		n = 0;
		while (msg_code !== m && n < 300) begin
			@(posedge pclk);
			n++;
		end
		`CHK("msg", m, msg_code)
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h073F);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		`CHK("slverr", 1'b1, er_q)
		push(5'h1F);
		rd(8'h08, 32'h0);
		push(5'h00);
		apb(1'b1, 8'h00, 32'h9);
		push(5'h01);
		rd(8'h08, 32'h0);
		push(5'h00);
		apb(1'b1, 8'h00, 32'h000A9000);
		push(5'h18);
		rd(8'h08, 32'h0C);
		push(5'h00);
		apb(1'b1, 8'h08, 32'h1F);
		rd(8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h606);
		apb(1'b1, 8'h0C, 32'h2);
		push(5'h04);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, 8'h08, 32'h2);
		repeat (2) @(posedge pclk);
		`CHK("irq", 1'b0, irq)
		push(5'h00);
		apb(1'b1, 8'h0C, 32'h0);
		push(5'h01);
		`CHK("irq", 1'b0, irq)
		rd(8'h08, 32'h2);
		push(5'h00);
		apb(1'b1, 8'h08, 32'h1F);
		apb(1'b1, 8'h00, 32'hB870);
		apb(1'b1, 8'h04, 32'h0530);
		push(5'h0E);
		`CHK("gate", 1'b1, setup_gate)
		`CHK("bright", 6'h05, brightness)
		`CHK("inhibit", 1'b1, count_inhibit)
		push(5'h00);
		`CHK("gate", 1'b0, setup_gate)
		`CHK("bright", 6'h30, brightness)
		`CHK("inhibit", 1'b0, count_inhibit)
		apb(1'b1, 8'h00, 32'h20);
		meas_value <= 16'h0064;
		push(5'h02);
		meas_value <= 16'h00C8;
		wait_msg(3'h2);
		`CHK("held", 16'h0064, shown_value)
		push(5'h00);
		apb(1'b1, 8'h00, 32'h10);
		meas_value <= 16'h0064;
		push(5'h02);
		meas_value <= 16'h012C;
		repeat (3) @(posedge pclk);
		`CHK("peak", 16'h012C, shown_value)
		meas_value <= 16'h0032;
		repeat (3) @(posedge pclk);
		`CHK("peak", 16'h012C, shown_value)
		wait_msg(3'h1);
		push(5'h00);
		apb(1'b1, 8'h00, 32'h3);
		push(5'h01);
		wait_msg(3'h5);
		rd(8'h08, 32'h11);
		push(5'h00);
		apb(1'b1, 8'h08, 32'h1F);
		meas_value <= 16'h0046;
		repeat (3) @(posedge pclk);
		meas_value <= 16'h0028;
		repeat (300) @(posedge pclk);
		push(5'h01);
		`CHK("recall", 16'h0046, shown_value)
		push(5'h00);
		`CHK("recall", 16'h0046, shown_value)
		repeat (220) @(posedge pclk);
		`CHK("normal", 16'h0028, shown_value)
		meas_value <= 16'h0050;
		apb(1'b1, 8'h00, 32'h4);
		push(5'h01);
		`CHK("valley", 16'h0028, shown_value)
		push(5'h00);
		repeat (240) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h5);
		key <= 5'h01;
		wait_msg(3'h3);
		push(5'h01);
		`CHK("toggle", 16'h0050, shown_value)
		push(5'h00);
		repeat (240) @(posedge pclk);
		key <= 5'h01;
		wait_msg(3'h4);
		push(5'h01);
		`CHK("toggle", 16'h0028, shown_value)
		push(5'h00);
		report_and_stop;
	end
endmodule
